// ---- hw/bcs_defines.svh ----
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// ---------------------------------------------------------------
// Register port word indices
// ---------------------------------------------------------------
`define BCS_ADDR_W_FIRST 5'h00
`define BCS_ADDR_W_LAST 5'h0f
`define BCS_ADDR_STATUS 5'h10
`define BCS_ADDR_SP 5'h11
`define BCS_ADDR_REPEAT 5'h12

// ---------------------------------------------------------------
// Status register field positions and reset value
// ---------------------------------------------------------------
`define BCS_SR_C 0
`define BCS_SR_Z 1
`define BCS_SR_OV 2
`define BCS_SR_N 3
`define BCS_SR_SFA 4
`define BCS_SR_DC 8
`define BCS_SR_SLEEP 12
`define BCS_SR_IDLE 13
`define BCS_SR_WATCHDOG_TIMEOUT_FLAG 14
`define BCS_SR_RESET 16'h0000

// ---------------------------------------------------------------
// Cycle counts
// ---------------------------------------------------------------
`define BCS_CYC_BASE 4'h1
`define BCS_CYC_SKIP_SHORT 4'h2
`define BCS_CYC_SKIP_LONG 4'h3
`define BCS_CYC_DOUBLE 4'h2
`define BCS_CYC_CALL 4'h4
`define BCS_CYC_BRANCH 4'h5
`define BCS_CYC_RET 4'h6
`define BCS_CYC_RET_SHORT 4'h5
`define BCS_CYC_SFR_EXTRA 4'h1

`endif

// ---- hw/bcs_pkg.sv ----
package bcs_pkg;

    typedef enum logic [4:0] {
        BCS_OP_NOP = 5'h00,
        BCS_OP_TOGGLE_BIT,
        BCS_OP_SKIP_IF_BIT_CLEAR,
        BCS_OP_SKIP_IF_BIT_SET,
        BCS_OP_TEST_THEN_SET_C,
        BCS_OP_TEST_THEN_SET_Z,
        BCS_OP_CALL_LIT,
        BCS_OP_CALL_REG,
        BCS_OP_COMPARE_WITH_ZERO,
        BCS_OP_COMPARE_WITH_BORROW,
        BCS_OP_COMPARE_SKIP,
        BCS_OP_COMPARE_BRANCH,
        BCS_OP_POP,
        BCS_OP_POP_D,
        BCS_OP_PUSH,
        BCS_OP_PUSH_D,
        BCS_OP_REPEAT,
        BCS_OP_RETURN,
        BCS_OP_RETURN_WITH_LITERAL,
        BCS_OP_POWER_SAVE_ENTRY,
        BCS_OP_ROTATE_LEFT_VIA_CARRY,
        BCS_OP_ROTATE_RIGHT_PLAIN,
        BCS_OP_SIGN_EXTEND_OP
    } bcs_op_t;

    typedef enum logic [1:0] {
        BCS_REL_EQUAL = 2'h0,
        BCS_REL_GREATER = 2'h1,
        BCS_REL_LESS = 2'h2,
        BCS_REL_NOT_EQUAL = 2'h3
    } bcs_rel_t;

    typedef enum logic [2:0] {
        BCS_ST_IDLE = 3'b001,
        BCS_ST_RUN = 3'b010,
        BCS_ST_SAVE = 3'b100
    } bcs_state_t;

    typedef struct packed {
        bcs_op_t code;
        bcs_rel_t rel;
        logic [3:0] ws;
        logic [3:0] wb;
        logic [3:0] wd;
        logic [15:0] lit;
        logic use_lit;
        logic src_file;
        logic dst_file;
        logic bit_reg;
        logic sfr;
        logic next_long;
        logic short_ret;
        logic [15:0] fdata;
        logic [15:0] ret_addr;
    } bcs_req_t;

endpackage

// ---- hw/bcs_exec_unit.sv ----
// Behaviour
// - Skip-if-bit-clear: one word, 1 cycle, 2 or 3 when skipping, no flags.
// - Skip-if-bit-set skips only when the bit is one; same size and cost.
// - Test-then-set to carry copies bit into C, then sets it; 1 cycle.
// - Test-then-set to zero loads Z with the complement of the bit, sets it; only Z; 1 cycle.
// - All call forms take 4 cycles and update the stack-frame-active flag.
// - Compare with zero: 1 cycle, updates C, DC, N, OV, Z, writes nothing.
// - Compare with borrow: first minus second minus not-carry, flags only, 1 cycle.
// - Compare-and-skip skips when relation holds; 1 or 2-3 cycles; no flags.
// - Compare-and-branch branches when relation holds; 1 or 5 cycles; no flags.
// - Double pop fills a register pair in 2 cycles; single pop 1; no flags.
// - Double push stores a register pair in 2 cycles; single push 1; no flags.
// - Repeat runs the next operation literal-or-register plus one times; 1 cycle.
// - Returns take 6 cycles, 5 reduced; literal form loads 10-bit literal.
// - Power save enters sleep or idle by literal; clears the watchdog flag, sets the sleep or idle flag.
// - Rotate left through carry; old carry to bit 0, top bit to C; C, N, Z.
// - Rotate right with wraparound; only N and Z; 1 cycle.
// - Sign extend into destination register; updates C, N, Z in 1 cycle.
// - Reads of peripheral registers outside the core cost one extra cycle, except in test-then-set to carry and sign extend.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_exec_unit import bcs_pkg::*; #(
    parameter int STACK_DEPTH = 32
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Operation request
    input wire logic i_op_valid,
    input wire bcs_op_t i_op_code,
    input wire bcs_rel_t i_op_rel,
    input wire logic [3:0] i_op_ws,
    input wire logic [3:0] i_op_wb,
    input wire logic [3:0] i_op_wd,
    input wire logic [15:0] i_op_lit,
    input wire logic i_op_use_lit,
    input wire logic i_op_src_file,
    input wire logic i_op_dst_file,
    input wire logic i_op_bit_reg,
    input wire logic i_op_sfr,
    input wire logic i_op_next_long,
    input wire logic i_op_short_ret,
    input wire logic [15:0] i_op_fdata,
    input wire logic [15:0] i_ret_addr,
    // Wake pin
    input wire logic i_wake,
    // Register port
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Completion
    output logic o_busy,
    output logic o_done,
    output logic [3:0] o_cycles,
    output logic o_skip,
    output logic o_branch,
    output logic [15:0] o_target,
    output logic o_f_we,
    output logic [15:0] o_f_wdata,
    output logic o_repeat_active,
    output logic o_sleep,
    output logic o_idle
);

    localparam int SP_W = $clog2(STACK_DEPTH);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    bcs_state_t state, next_state;
    bcs_req_t req, next_req;
    logic [3:0] elapsed, next_elapsed;
    logic [15:0] wreg [16];
    logic [15:0] next_wreg [16];
    logic [15:0] stk [STACK_DEPTH];
    logic [15:0] next_stk [STACK_DEPTH];
    logic [SP_W-1:0] sp, next_sp;
    logic [15:0] sr, next_sr;
    logic [15:0] rpt_left, next_rpt_left;
    logic wake_s1, wake_s2, wake_s3;
    logic [15:0] next_rdata, next_target, next_f_wdata;
    logic [3:0] next_cycles;
    logic next_busy, next_done, next_skip, next_branch, next_f_we, next_sleep, next_idle;

    // ---------------------------------------------------------------
    // Execute datapath
    // ---------------------------------------------------------------
    logic [15:0] op_a, op_b, mask, res, tgt, w0_dat, w1_dat, push0, push1, cmp_l, cmp_r;
    logic [16:0] diff;
    logic [4:0] nib;
    logic [3:0] bit_pos, w0_idx, w1_idx, total;
    logic [15:0] flags;
    logic bit_val, rel_hit, res_we, skip, brn, w0_we, w1_we, rpt_load, wants_file;
    logic [1:0] push_n, pop_n;
    logic [SP_W-1:0] sp_m1, sp_m2;
    logic accept, commit, wake_ok;

    assign sp_m1 = sp - SP_W'(1);
    assign sp_m2 = sp - SP_W'(2);

    always_comb begin
        op_a = req.src_file ? req.fdata : wreg[req.ws];
        op_b = req.use_lit ? req.lit : wreg[req.wb];
        bit_pos = req.bit_reg ? wreg[req.wb][3:0] : req.lit[3:0];
        bit_val = op_a[bit_pos];
        mask = 16'h0001 << bit_pos;
        diff = {1'b0, op_a} + {1'b0, ~op_b} + {16'h0000, sr[`BCS_SR_C]};
        nib = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + {4'h0, sr[`BCS_SR_C]};
        cmp_l = wreg[req.wb];
        cmp_r = wreg[req.ws];
        case (req.rel)
            BCS_REL_EQUAL: rel_hit = cmp_l == cmp_r;
            BCS_REL_GREATER: rel_hit = $signed(cmp_l) > $signed(cmp_r);
            BCS_REL_LESS: rel_hit = $signed(cmp_l) < $signed(cmp_r);
            default: rel_hit = cmp_l != cmp_r;
        endcase
        total = `BCS_CYC_BASE;
        res = 16'h0000;
        res_we = 1'b0;
        skip = 1'b0;
        brn = 1'b0;
        tgt = 16'h0000;
        flags = sr;
        w1_we = 1'b0;
        w1_idx = req.wd;
        w1_dat = 16'h0000;
        push_n = 2'h0;
        push0 = 16'h0000;
        push1 = 16'h0000;
        pop_n = 2'h0;
        rpt_load = 1'b0;
        wants_file = 1'b0;
        case (req.code)
            BCS_OP_TOGGLE_BIT: begin
                res = op_a ^ mask;
                res_we = 1'b1;
                wants_file = 1'b1;
            end
            BCS_OP_SKIP_IF_BIT_CLEAR, BCS_OP_SKIP_IF_BIT_SET: begin
                skip = (req.code == BCS_OP_SKIP_IF_BIT_SET) ? bit_val : !bit_val;
                wants_file = 1'b1;
            end
            BCS_OP_TEST_THEN_SET_C: begin
                flags[`BCS_SR_C] = bit_val;
                res = op_a | mask;
                res_we = 1'b1;
            end
            BCS_OP_TEST_THEN_SET_Z: begin
                flags[`BCS_SR_Z] = !bit_val;
                res = op_a | mask;
                res_we = 1'b1;
                wants_file = 1'b1;
            end
            BCS_OP_CALL_LIT, BCS_OP_CALL_REG: begin
                total = `BCS_CYC_CALL;
                flags[`BCS_SR_SFA] = 1'b0;
                brn = 1'b1;
                tgt = (req.code == BCS_OP_CALL_LIT) ? req.lit : wreg[req.ws];
                push_n = 2'h1;
                push0 = req.ret_addr;
            end
            BCS_OP_COMPARE_WITH_ZERO: begin
                flags[`BCS_SR_C] = 1'b1;
                flags[`BCS_SR_DC] = 1'b1;
                flags[`BCS_SR_N] = op_a[15];
                flags[`BCS_SR_OV] = 1'b0;
                flags[`BCS_SR_Z] = op_a == 16'h0000;
                wants_file = 1'b1;
            end
            BCS_OP_COMPARE_WITH_BORROW: begin
                flags[`BCS_SR_C] = diff[16];
                flags[`BCS_SR_DC] = nib[4];
                flags[`BCS_SR_N] = diff[15];
                flags[`BCS_SR_OV] = (op_a[15] != op_b[15]) && (diff[15] != op_a[15]);
                // Zero only clears, so a multi-word compare chain keeps its result
                flags[`BCS_SR_Z] = sr[`BCS_SR_Z] && (diff[15:0] == 16'h0000);
                wants_file = 1'b1;
            end
            BCS_OP_COMPARE_SKIP: begin
                skip = rel_hit;
            end
            BCS_OP_COMPARE_BRANCH: begin
                brn = rel_hit;
                tgt = req.lit;
                total = rel_hit ? `BCS_CYC_BRANCH : `BCS_CYC_BASE;
            end
            BCS_OP_POP: begin
                res = stk[sp_m1];
                res_we = 1'b1;
                pop_n = 2'h1;
            end
            BCS_OP_POP_D: begin
                total = `BCS_CYC_DOUBLE;
                res = stk[sp_m2];
                res_we = 1'b1;
                w1_we = 1'b1;
                w1_idx = req.wd + 4'h1;
                w1_dat = stk[sp_m1];
                pop_n = 2'h2;
            end
            BCS_OP_PUSH: begin
                push_n = 2'h1;
                push0 = op_a;
                wants_file = 1'b1;
            end
            BCS_OP_PUSH_D: begin
                total = `BCS_CYC_DOUBLE;
                push_n = 2'h2;
                push0 = wreg[req.ws];
                push1 = wreg[req.ws + 4'h1];
            end
            BCS_OP_REPEAT: begin
                rpt_load = 1'b1;
            end
            BCS_OP_RETURN, BCS_OP_RETURN_WITH_LITERAL: begin
                total = req.short_ret ? `BCS_CYC_RET_SHORT : `BCS_CYC_RET;
                flags[`BCS_SR_SFA] = 1'b0;
                brn = 1'b1;
                tgt = stk[sp_m1];
                pop_n = 2'h1;
                res = {6'h00, req.lit[9:0]};
                res_we = req.code == BCS_OP_RETURN_WITH_LITERAL;
            end
            BCS_OP_POWER_SAVE_ENTRY: begin
                flags[`BCS_SR_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
                flags[`BCS_SR_SLEEP] = sr[`BCS_SR_SLEEP] || !req.lit[0];
                flags[`BCS_SR_IDLE] = sr[`BCS_SR_IDLE] || req.lit[0];
            end
            BCS_OP_ROTATE_LEFT_VIA_CARRY: begin
                res = {op_a[14:0], sr[`BCS_SR_C]};
                res_we = 1'b1;
                flags[`BCS_SR_C] = op_a[15];
                flags[`BCS_SR_N] = op_a[14];
                flags[`BCS_SR_Z] = res == 16'h0000;
                wants_file = 1'b1;
            end
            BCS_OP_ROTATE_RIGHT_PLAIN: begin
                res = {op_a[0], op_a[15:1]};
                res_we = 1'b1;
                flags[`BCS_SR_N] = op_a[0];
                flags[`BCS_SR_Z] = op_a == 16'h0000;
                wants_file = 1'b1;
            end
            BCS_OP_SIGN_EXTEND_OP: begin
                res = {{8{op_a[7]}}, op_a[7:0]};
                res_we = 1'b1;
                flags[`BCS_SR_C] = !op_a[7];
                flags[`BCS_SR_N] = op_a[7];
                flags[`BCS_SR_Z] = op_a[7:0] == 8'h00;
            end
            default: begin
                total = `BCS_CYC_BASE;
            end
        endcase
        if (skip) begin
            total = req.next_long ? `BCS_CYC_SKIP_LONG : `BCS_CYC_SKIP_SHORT;
        end
        if (wants_file && req.src_file && req.sfr) begin
            total = total + `BCS_CYC_SFR_EXTRA;
        end
        w0_we = res_we && !(req.dst_file && req.code != BCS_OP_SIGN_EXTEND_OP);
        w0_idx = req.wd;
        if (req.code == BCS_OP_TOGGLE_BIT || req.code == BCS_OP_TEST_THEN_SET_C
            || req.code == BCS_OP_TEST_THEN_SET_Z) begin
            w0_idx = req.ws;
        end
        w0_dat = res;
    end

    // ---------------------------------------------------------------
    // Sequencer, register file and stack
    // ---------------------------------------------------------------
    // Bus writes to a working register are overridden by a same-cycle commit
    assign accept = i_op_valid && (state == BCS_ST_IDLE);
    assign commit = (state == BCS_ST_RUN) && (elapsed == total - 4'h1);
    assign wake_ok = wake_s2 && wake_s3;

    always_comb begin
        next_state = state;
        next_req = accept ? {i_op_code, i_op_rel, i_op_ws, i_op_wb, i_op_wd, i_op_lit,
            i_op_use_lit, i_op_src_file, i_op_dst_file, i_op_bit_reg, i_op_sfr,
            i_op_next_long, i_op_short_ret, i_op_fdata, i_ret_addr} : req;
        next_elapsed = accept ? 4'h0 : elapsed + 4'h1;
        next_wreg = wreg;
        next_stk = stk;
        next_sp = sp;
        next_sr = sr;
        next_rpt_left = rpt_left;
        next_sleep = o_sleep;
        next_idle = o_idle;
        next_target = o_target;
        next_f_wdata = o_f_wdata;
        next_cycles = o_cycles;
        if (i_wr && i_addr <= `BCS_ADDR_W_LAST) begin
            next_wreg[i_addr[3:0]] = i_wdata;
        end else if (i_wr && i_addr == `BCS_ADDR_STATUS) begin
            next_sr = i_wdata;
        end
        case (state)
            BCS_ST_IDLE: begin
                if (accept) begin
                    next_state = BCS_ST_RUN;
                end
            end
            BCS_ST_RUN: begin
                if (commit) begin
                    next_state = (req.code == BCS_OP_POWER_SAVE_ENTRY) ? BCS_ST_SAVE : BCS_ST_IDLE;
                end
            end
            BCS_ST_SAVE: begin
                if (wake_ok) begin
                    next_state = BCS_ST_IDLE;
                    next_sleep = 1'b0;
                    next_idle = 1'b0;
                end
            end
            default: begin
                next_state = BCS_ST_IDLE;
            end
        endcase
        if (commit) begin
            next_sr = flags;
            next_cycles = total;
            next_target = tgt;
            next_f_wdata = res;
            if (w0_we) begin
                next_wreg[w0_idx] = w0_dat;
            end
            if (w1_we) begin
                next_wreg[w1_idx] = w1_dat;
            end
            if (push_n != 2'h0) begin
                next_stk[sp] = push0;
            end
            if (push_n == 2'h2) begin
                next_stk[sp + SP_W'(1)] = push1;
            end
            next_sp = sp + SP_W'(push_n) - SP_W'(pop_n);
            if (rpt_load) begin
                next_rpt_left = req.use_lit ? {1'b0, req.lit[14:0]} : wreg[req.ws];
            end else if (rpt_left != 16'h0000) begin
                next_rpt_left = rpt_left - 16'h0001;
            end
            if (req.code == BCS_OP_POWER_SAVE_ENTRY) begin
                next_sleep = !req.lit[0];
                next_idle = req.lit[0];
            end
        end
        next_busy = next_state != BCS_ST_IDLE;
        next_done = commit;
        next_skip = commit && skip;
        next_branch = commit && brn;
        next_f_we = commit && res_we && req.dst_file && req.code != BCS_OP_SIGN_EXTEND_OP;
        next_rdata = 16'h0000;
        if (i_rd && i_addr <= `BCS_ADDR_W_LAST) begin
            next_rdata = wreg[i_addr[3:0]];
        end else if (i_rd && i_addr == `BCS_ADDR_STATUS) begin
            next_rdata = sr;
        end else if (i_rd && i_addr == `BCS_ADDR_SP) begin
            next_rdata = 16'(sp);
        end else if (i_rd && i_addr == `BCS_ADDR_REPEAT) begin
            next_rdata = rpt_left;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= BCS_ST_IDLE;
            req <= '0;
            elapsed <= 4'h0;
            wreg <= '{default: 16'h0000};
            stk <= '{default: 16'h0000};
            sp <= '0;
            sr <= `BCS_SR_RESET;
            rpt_left <= 16'h0000;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
            o_rdata <= 16'h0000;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_cycles <= 4'h0;
            o_skip <= 1'b0;
            o_branch <= 1'b0;
            o_target <= 16'h0000;
            o_f_we <= 1'b0;
            o_f_wdata <= 16'h0000;
            o_repeat_active <= 1'b0;
            o_sleep <= 1'b0;
            o_idle <= 1'b0;
        end else begin
            state <= next_state;
            req <= next_req;
            elapsed <= next_elapsed;
            wreg <= next_wreg;
            stk <= next_stk;
            sp <= next_sp;
            sr <= next_sr;
            rpt_left <= next_rpt_left;
            wake_s1 <= i_wake;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
            o_rdata <= next_rdata;
            o_busy <= next_busy;
            o_done <= next_done;
            o_cycles <= next_cycles;
            o_skip <= next_skip;
            o_branch <= next_branch;
            o_target <= next_target;
            o_f_we <= next_f_we;
            o_f_wdata <= next_f_wdata;
            o_repeat_active <= next_rpt_left != 16'h0000;
            o_sleep <= next_sleep;
            o_idle <= next_idle;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_take(bcs_op_t c);
        accept && i_op_code == c && !i_op_src_file;
    endsequence

    chk_test_set_one: assert property (s_take(BCS_OP_TEST_THEN_SET_C) |-> ##2 o_done)
        else $error("test-then-set not done in one cycle");
    chk_call_four: assert property (s_take(BCS_OP_CALL_LIT)
        |-> ##1 !o_done [*4] ##1 o_done)
        else $error("call not done in four cycles");
    chk_ret_short: assert property (accept && i_op_short_ret
        && (i_op_code == BCS_OP_RETURN || i_op_code == BCS_OP_RETURN_WITH_LITERAL)
        |-> ##5 !o_done ##1 o_done && o_branch)
        else $error("reduced return not done in five cycles");
    chk_skip_flags: assert property (commit && skip |=> sr == $past(sr) && o_skip)
        else $error("skip changed status flags");
    chk_branch_five: assert property (commit && brn && req.code == BCS_OP_COMPARE_BRANCH
        |-> $past(accept, 5))
        else $error("taken branch not five cycles");
    chk_rlc_carry: assert property (commit && req.code == BCS_OP_ROTATE_LEFT_VIA_CARRY
        |=> sr[`BCS_SR_C] == $past(op_a[15]))
        else $error("rotate left carry wrong");
    chk_cp0_zero: assert property (commit && req.code == BCS_OP_COMPARE_WITH_ZERO
        |=> sr[`BCS_SR_Z] == ($past(op_a) == 16'h0000) && sr[`BCS_SR_C])
        else $error("compare with zero flags wrong");
    chk_sleep_entry: assert property (commit && req.code == BCS_OP_POWER_SAVE_ENTRY
        && !req.lit[0] |=> o_sleep && sr[`BCS_SR_SLEEP] && !sr[`BCS_SR_WATCHDOG_TIMEOUT_FLAG])
        else $error("sleep entry wrong");
    chk_push_pair: assert property (commit && req.code == BCS_OP_PUSH_D
        |-> elapsed == 4'h1 ##1 sp == $past(sp) + SP_W'(2))
        else $error("double push wrong");
    chk_repeat_load: assert property (commit && rpt_load && req.use_lit
        |=> rpt_left == {1'b0, $past(req.lit[14:0])} && o_repeat_active == (rpt_left != 16'h0000))
        else $error("repeat count not loaded");

endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top import bcs_pkg::*;;
    // ----
    // Stimulus, model state
    // ----
    logic i_core_clk = '0, i_reset_n = '0, i_op_valid = '0, i_op_use_lit = '0;
    logic i_op_src_file = '0, i_op_dst_file = '0, i_op_bit_reg = '0, i_op_sfr = '0;
    logic i_op_next_long = '0, i_op_short_ret = '0, i_wake = '0, i_wr = '0, i_rd = '0;
    logic o_busy, o_done, o_skip, o_branch, o_f_we, o_repeat_active, o_sleep, o_idle;
    logic [3:0] i_op_ws = '0, i_op_wb = '0, i_op_wd = '0, o_cycles, k;
    logic [15:0] i_op_lit = '0, i_op_fdata = '0, i_ret_addr = '0, i_wdata = '0;
    logic [15:0] o_rdata, o_target, o_f_wdata, a, b, r, t;
    logic [4:0] i_addr = '0;
    bcs_op_t i_op_code = BCS_OP_NOP;
    bcs_rel_t i_op_rel = BCS_REL_EQUAL;
    logic [15:0] w [16];
    logic [15:0] stk [$];
    logic [31:0] seed = 32'h42c7;
    logic e;
    int err_count = 0, check_count = 0, n, i, cyc = 0;
    bcs_exec_unit i_dut (.*);
    always #4 i_core_clk = ~i_core_clk;
    // Hang guard: whole run needs well under this many cycles
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input logic [15:0] g, x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wrr(input logic [4:0] ad, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [4:0] ad, input logic [15:0] x);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= ad;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(posedge i_core_clk);
        chk(o_rdata, x);
    endtask
    // Issue one op, wait for done (bounded), compare done, skip, branch and cycles
    task automatic op(input bcs_op_t c, input logic [3:0] s, bb, d, input logic [15:0] l,
                      input logic [3:0] ec, input logic es, eb);
        @(posedge i_core_clk);
        i_op_valid <= 1'b1;
        i_op_code <= c;
        i_op_ws <= s;
        i_op_wb <= bb;
        i_op_wd <= d;
        i_op_lit <= l;
        @(posedge i_core_clk);
        i_op_valid <= 1'b0;
        for (n = 0; n < 12 && o_done !== 1'b1; n++) @(posedge i_core_clk);
        chk({9'h0, o_done, o_skip, o_branch, o_cycles}, {9'h0, 1'b1, es, eb, ec});
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        for (i = 0; i < 16; i++) begin
            w[i] = xs();
            wrr(i[4:0], w[i]);
        end
        rdc(5'h1f, 16'h0);
        for (i = 0; i < 12; i++) begin
            t = xs();
            i_op_bit_reg <= t[4];
            i_op_next_long <= t[5];
            e = w[t[15:12]][t[4] ? w[t[11:8]][3:0] : t[3:0]] == t[6];
            k = e ? (t[5] ? 4'h3 : 4'h2) : 4'h1;
            op(t[6] ? BCS_OP_SKIP_IF_BIT_SET : BCS_OP_SKIP_IF_BIT_CLEAR, t[15:12], t[11:8], 4'h0, t, k, e, 1'b0);
        end
        i_op_bit_reg <= 1'b0;
        i_op_next_long <= 1'b0;
        for (i = 0; i < 2; i++) begin
            t = xs();
            wrr(5'h10, 16'h0);
            e = w[1][t[3:0]];
            op(i ? BCS_OP_TEST_THEN_SET_Z : BCS_OP_TEST_THEN_SET_C, 4'h1, 4'h0, 4'h0, t, 4'h1, 1'b0, 1'b0);
            w[1][t[3:0]] = 1'b1;
            rdc(5'h1, w[1]);
            rdc(5'h10, i ? {14'h0, !e, 1'b0} : {15'h0, e});
        end
        wrr(5'h10, 16'h0);
        for (i = 0; i < 8; i++) begin
            a = xs() & 16'h7fff;
            b = i[2] ? a : xs() & 16'h7fff;
            w[1] = a;
            w[2] = b;
            wrr(5'h1, a);
            wrr(5'h2, b);
            i_op_rel <= bcs_rel_t'(i[1:0]);
            e = (i[1:0] == 0 && a == b) || (i[1:0] == 1 && a > b) || (i[1:0] == 2 && a < b) || (i[1:0] == 3 && a != b);
            t = xs();
            op(BCS_OP_COMPARE_SKIP, 4'h2, 4'h1, 4'h0, t, e ? 4'h2 : 4'h1, e, 1'b0);
            op(BCS_OP_COMPARE_BRANCH, 4'h2, 4'h1, 4'h0, t, e ? 4'h5 : 4'h1, 1'b0, e);
            if (e) chk(o_target, t);
        end
        rdc(5'h10, 16'h0);
        t = xs();
        wrr(5'h10, {15'h0, t[0]});
        op(BCS_OP_ROTATE_LEFT_VIA_CARRY, 4'h1, 4'h0, 4'h3, 16'h0, 4'h1, 1'b0, 1'b0);
        r = {a[14:0], t[0]};
        rdc(5'h3, r);
        rdc(5'h10, {12'h0, r[15], 1'b0, r == 16'h0, 1'b0});
        b = {r[0], r[15:1]};
        op(BCS_OP_ROTATE_RIGHT_PLAIN, 4'h3, 4'h0, 4'h4, 16'h0, 4'h1, 1'b0, 1'b0);
        rdc(5'h4, b);
        rdc(5'h10, {12'h0, b[15], 1'b0, b == 16'h0, 1'b0});
        op(BCS_OP_PUSH_D, 4'h1, 4'h0, 4'h0, 16'h0, 4'h2, 1'b0, 1'b0);
        stk.push_back(w[1]);
        stk.push_back(w[2]);
        op(BCS_OP_PUSH, 4'h3, 4'h0, 4'h0, 16'h0, 4'h1, 1'b0, 1'b0);
        op(BCS_OP_POP, 4'h0, 4'h0, 4'h8, 16'h0, 4'h1, 1'b0, 1'b0);
        rdc(5'h8, r);
        op(BCS_OP_POP_D, 4'h0, 4'h0, 4'h6, 16'h0, 4'h2, 1'b0, 1'b0);
        rdc(5'h7, stk.pop_back());
        rdc(5'h6, stk.pop_back());
        t = xs();
        r = xs();
        i_ret_addr <= r;
        i_op_short_ret <= t[0];
        op(BCS_OP_CALL_LIT, 4'h0, 4'h0, 4'h0, t, 4'h4, 1'b0, 1'b1);
        chk(o_target, t);
        op(BCS_OP_RETURN_WITH_LITERAL, 4'h0, 4'h0, 4'h9, t, t[0] ? 4'h5 : 4'h6, 1'b0, 1'b1);
        chk(o_target, r);
        rdc(5'h9, {6'h0, t[9:0]});
        t = xs();
        wrr(5'h5, t);
        op(BCS_OP_SIGN_EXTEND_OP, 4'h5, 4'h0, 4'h5, 16'h0, 4'h1, 1'b0, 1'b0);
        r = {{8{t[7]}}, t[7:0]};
        rdc(5'h5, r);
        rdc(5'h10, {12'h0, r[15], 1'b0, r == 16'h0, !r[15]});
        i_op_src_file <= 1'b1;
        i_op_sfr <= 1'b1;
        op(BCS_OP_COMPARE_WITH_ZERO, 4'h0, 4'h0, 4'h0, 16'h0, 4'h2, 1'b0, 1'b0);
        rdc(5'h10, 16'h0103);
        i_op_use_lit <= 1'b1;
        op(BCS_OP_COMPARE_WITH_BORROW, 4'h0, 4'h0, 4'h0, 16'h0001, 4'h2, 1'b0, 1'b0);
        rdc(5'h10, 16'h0008);
        op(BCS_OP_REPEAT, 4'h0, 4'h0, 4'h0, 16'h0002, 4'h1, 1'b0, 1'b0);
        chk({15'h0, o_repeat_active}, 16'h1);
        rdc(5'h12, 16'h2);
        op(BCS_OP_NOP, 4'h0, 4'h0, 4'h0, 16'h0, 4'h1, 1'b0, 1'b0);
        rdc(5'h12, 16'h1);
        op(BCS_OP_POWER_SAVE_ENTRY, 4'h0, 4'h0, 4'h0, 16'h0, 4'h1, 1'b0, 1'b0);
        chk({13'h0, o_idle, o_sleep, o_busy}, 16'h3);
        i_wake <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        chk({13'h0, o_idle, o_sleep, o_busy}, 16'h0);
        i_wake <= 1'b0;
        rdc(5'h10, 16'h1008);
        i_op_dst_file <= 1'b1;
        i_op_fdata <= t;
        op(BCS_OP_TOGGLE_BIT, 4'h0, 4'h0, 4'h0, 16'h0005, 4'h2, 1'b0, 1'b0);
        chk({15'h0, o_f_we}, 16'h1);
        chk(o_f_wdata, t ^ 16'h0020);
        wrap_up();
    end
endmodule
`default_nettype wire
